// ==== rtl/instruction_cycle_sequencer_regs.svh ====
// constants for the instruction cycle sequencer
`ifndef INSTRUCTION_CYCLE_SEQUENCER_REGS_SVH
`define INSTRUCTION_CYCLE_SEQUENCER_REGS_SVH

`define PHASES_PER_CYCLE   3'h4
`define PHASE_ONE_IDX      2'h0
`define PHASE_TWO_IDX      2'h1
`define PHASE_THREE_IDX    2'h2
`define PHASE_FOUR_IDX     2'h3
`define OSC_SEL_LP         2'h0
`define OSC_SEL_XT         2'h1
`define OSC_SEL_HS         2'h2
`define OSC_SEL_RC         2'h3
`define PC_RESET_VALUE     16'hFFFF
`define BRANCH_CYCLES      2'h2

`endif

// ==== rtl/instruction_cycle_sequencer_pkg.sv ====
// types for the instruction cycle sequencer
package instruction_cycle_sequencer_pkg;
  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE,
    CRYSTAL_RESONATOR_MODE,
    HIGH_SPEED_CRYSTAL_MODE,
    RESISTOR_CAPACITOR_MODE
  } osc_mode_t;

  typedef enum logic [1:0] {
    PHASE_ONE,
    PHASE_TWO,
    PHASE_THREE,
    PHASE_FOUR
  } phase_t;

  typedef struct packed {
    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;
  } phase_strobes_t;

  typedef struct packed {
    logic operand_read;
    logic result_write;
    logic valid;
  } exec_ctl_t;
endpackage

// ==== rtl/instruction_cycle_sequencer.sv ====
// four-phase instruction cycle generator with two-stage fetch/execute pipeline
`timescale 1ns/1ps
`default_nettype none
`include "instruction_cycle_sequencer_regs.svh"

module instruction_cycle_sequencer #(
  parameter int PC_W    = 11,
  parameter int INSTR_W = 12,
  parameter logic [3:0] MODES_OFFERED = 4'hF
) (
  input  wire logic                                        clk,
  input  wire logic                                        master_clear_n,
  input  wire logic [1:0]                                  osc_select_bits,
  input  wire logic [INSTR_W-1:0]                          prog_rdata,
  input  wire logic                                        exec_branch,
  input  wire logic [PC_W-1:0]                             branch_target,
  output logic [PC_W-1:0]                                  prog_addr,
  output logic [INSTR_W-1:0]                               decode_word,
  output instruction_cycle_sequencer_pkg::phase_strobes_t phase_strobes,
  output instruction_cycle_sequencer_pkg::exec_ctl_t      exec_ctl,
  output instruction_cycle_sequencer_pkg::osc_mode_t      osc_mode,
  output logic                                             cycle_clock_output,
  output logic                                             cycle_clock_oe
);

  instruction_cycle_sequencer_pkg::phase_t         phase_r;
  instruction_cycle_sequencer_pkg::phase_t         phase_nxt;
  instruction_cycle_sequencer_pkg::phase_strobes_t strobes_nxt;
  instruction_cycle_sequencer_pkg::osc_mode_t      mode_nxt;
  logic [PC_W-1:0]                                 pc_r;
  logic [INSTR_W-1:0]                              fetch_r;
  logic                                            fetch_valid_r;
  logic                                            exec_valid_r;
  logic                                            exec_valid_nxt;
  logic                                            cycle_start;
  logic                                            take_branch;
  logic                                            cfg_taken_r;
  logic                                            rc_mode;

  // phase counter; held at phase_four so release starts at phase_one
  always_comb begin
    case (phase_r)
      instruction_cycle_sequencer_pkg::PHASE_ONE:   phase_nxt = instruction_cycle_sequencer_pkg::PHASE_TWO;
      instruction_cycle_sequencer_pkg::PHASE_TWO:   phase_nxt = instruction_cycle_sequencer_pkg::PHASE_THREE;
      instruction_cycle_sequencer_pkg::PHASE_THREE: phase_nxt = instruction_cycle_sequencer_pkg::PHASE_FOUR;
      default:                                      phase_nxt = instruction_cycle_sequencer_pkg::PHASE_ONE;
    endcase
  end

  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      phase_r <= instruction_cycle_sequencer_pkg::PHASE_FOUR;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // the pc and execute stage move on the edge that opens phase_one; the fetch latch loads on the edge that opens phase_four
  assign cycle_start = (phase_nxt == instruction_cycle_sequencer_pkg::PHASE_ONE);

  // strobes registered one ahead so they line up with phase_r
  always_comb begin
    strobes_nxt = '0;
    case (phase_nxt)
      instruction_cycle_sequencer_pkg::PHASE_ONE:   strobes_nxt.phase_one   = 1'b1;
      instruction_cycle_sequencer_pkg::PHASE_TWO:   strobes_nxt.phase_two   = 1'b1;
      instruction_cycle_sequencer_pkg::PHASE_THREE: strobes_nxt.phase_three = 1'b1;
      instruction_cycle_sequencer_pkg::PHASE_FOUR:  strobes_nxt.phase_four  = 1'b1;
      default:                                      strobes_nxt             = '0;
    endcase
  end

  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      phase_strobes <= '0;
    end else begin
      phase_strobes <= strobes_nxt;
    end
  end

  // a branch request counts only while a real instruction executes
  assign take_branch    = cycle_start && exec_branch && exec_valid_r;
  // the word fetched beside a taken branch must not reach execute
  assign exec_valid_nxt = fetch_valid_r && !take_branch;

  // program counter: branch target loads at the next phase_one, else increment
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      pc_r <= PC_W'(`PC_RESET_VALUE);
    end else if (take_branch) begin
      pc_r <= branch_target;
    end else if (cycle_start) begin
      pc_r <= pc_r + PC_W'(1);
    end
  end

  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      prog_addr <= '0;
    end else begin
      prog_addr <= pc_r;
    end
  end

  // fetch latch
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      fetch_r <= '0;
    end else if (phase_nxt == instruction_cycle_sequencer_pkg::PHASE_FOUR) begin
      fetch_r <= prog_rdata;
    end
  end

  // a taken branch empties the slot until the target word is latched
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      fetch_valid_r <= 1'b0;
    end else if (phase_nxt == instruction_cycle_sequencer_pkg::PHASE_FOUR) begin
      fetch_valid_r <= 1'b1;
    end else if (take_branch) begin
      fetch_valid_r <= 1'b0;
    end
  end

  // empty or flushed slot decodes as all zeros
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      decode_word <= '0;
    end else if (cycle_start) begin
      decode_word <= exec_valid_nxt ? fetch_r : '0;
    end
  end

  // first cycle after reset runs empty since nothing was fetched
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      exec_valid_r <= 1'b0;
    end else if (cycle_start) begin
      exec_valid_r <= exec_valid_nxt;
    end
  end

  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      exec_ctl <= '0;
    end else begin
      exec_ctl.valid        <= cycle_start ? exec_valid_nxt : exec_valid_r;
      exec_ctl.operand_read <= (phase_nxt == instruction_cycle_sequencer_pkg::PHASE_TWO) && exec_valid_r;
      exec_ctl.result_write <= (phase_nxt == instruction_cycle_sequencer_pkg::PHASE_FOUR) && exec_valid_r;
    end
  end

  // mode in force; the first edge after release already acts on the new selection
  always_comb begin
    mode_nxt = osc_mode;
    if (!cfg_taken_r) begin
      // unoffered selection falls back to crystal_resonator_mode
      if (MODES_OFFERED[osc_select_bits]) begin
        mode_nxt = instruction_cycle_sequencer_pkg::osc_mode_t'(osc_select_bits);
      end else begin
        mode_nxt = instruction_cycle_sequencer_pkg::CRYSTAL_RESONATOR_MODE;
      end
    end
  end

  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      osc_mode <= instruction_cycle_sequencer_pkg::LOW_POWER_CRYSTAL_MODE;
    end else begin
      osc_mode <= mode_nxt;
    end
  end

  // configuration bits are nonvolatile, so sample once after release
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      cfg_taken_r <= 1'b0;
    end else begin
      cfg_taken_r <= 1'b1;
    end
  end

  assign rc_mode = (mode_nxt == instruction_cycle_sequencer_pkg::RESISTOR_CAPACITOR_MODE);

  // in rc_mode high during phase_one and phase_two, low during phase_three and phase_four; low throughout in crystal modes
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      cycle_clock_output <= 1'b0;
    end else begin
      cycle_clock_output <= rc_mode && (phase_nxt == instruction_cycle_sequencer_pkg::PHASE_ONE ||
                                        phase_nxt == instruction_cycle_sequencer_pkg::PHASE_TWO);
    end
  end

  // crystal modes leave the pin to the resonator
  always_ff @(posedge clk or negedge master_clear_n) begin
    if (!master_clear_n) begin
      cycle_clock_oe <= 1'b0;
    end else begin
      cycle_clock_oe <= rc_mode;
    end
  end

endmodule // instruction_cycle_sequencer

`default_nettype wire

// ==== testbench/instruction_cycle_sequencer_chk.sv ====
// checker for the instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_sequencer_chk (
  input wire logic                                            clk,
  input wire logic                                            master_clear_n,
  input wire logic                                            exec_branch,
  input wire instruction_cycle_sequencer_pkg::phase_strobes_t phase_strobes,
  input wire instruction_cycle_sequencer_pkg::exec_ctl_t      exec_ctl,
  input wire logic                                            cycle_clock_output,
  input wire logic                                            cycle_clock_oe
);
  wire [3:0] ps = phase_strobes;
  wire       v  = exec_ctl.valid;
  default clocking @(posedge clk); endclocking
  default disable iff (!master_clear_n);
  // first edge after release still samples the cleared strobes
  a_phase_onehot: assert property ($past(master_clear_n) |-> $onehot(ps)) else $error("phases not one-hot");
  a_phase_order: assert property (ps[3] |=> ps[2] ##1 ps[1] ##1 ps[0] ##1 ps[3]) else $error("phase order");
  a_flush_nop: assert property (ps[0] && v && exec_branch |=> !v [*4] ##1 v) else $error("flush cycle");
  a_exec_hold: assert property (!ps[3] |-> $stable(v)) else $error("valid moved");
  a_op_read: assert property (exec_ctl.operand_read == (ps[2] && v)) else $error("operand read");
  a_res_write: assert property (exec_ctl.result_write == (ps[0] && v)) else $error("result write");
  a_rc_clock: assert property (cycle_clock_oe |-> cycle_clock_output == (ps[3] || ps[2])) else $error("cycle clock");
  a_rc_only: assert property (cycle_clock_output |-> cycle_clock_oe) else $error("clock undriven");
  cover property (ps[0] && v && exec_branch);
  cover property (exec_ctl.result_write);
  cover property (cycle_clock_oe && cycle_clock_output);
endmodule // instruction_cycle_sequencer_chk
bind instruction_cycle_sequencer instruction_cycle_sequencer_chk chk_u (
  .clk                (clk),
  .master_clear_n     (master_clear_n),
  .exec_branch        (exec_branch),
  .phase_strobes      (phase_strobes),
  .exec_ctl           (exec_ctl),
  .cycle_clock_output (cycle_clock_output),
  .cycle_clock_oe     (cycle_clock_oe)
);
`default_nettype wire

// ==== testbench/instruction_cycle_sequencer_tb.sv ====
// bench for the instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_sequencer_tb;
  logic        clk = 1'b0, master_clear_n = 1'b0, exec_branch = 1'b0, cycle_clock_output, cycle_clock_oe;
  logic [1:0]  osc_select_bits = 2'h0, osc_mode;
  logic [2:0]  exec_ctl;
  logic [3:0]  phase_strobes;
  logic [10:0] branch_target = 11'h0, prog_addr;
  logic [11:0] prog_rdata = 12'h0, decode_word;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  instruction_cycle_sequencer dut_u (
    .clk                (clk),
    .master_clear_n     (master_clear_n),
    .osc_select_bits    (osc_select_bits),
    .prog_rdata         (prog_rdata),
    .exec_branch        (exec_branch),
    .branch_target      (branch_target),
    .prog_addr          (prog_addr),
    .decode_word        (decode_word),
    .phase_strobes      (phase_strobes),
    .exec_ctl           (exec_ctl),
    .osc_mode           (osc_mode),
    .cycle_clock_output (cycle_clock_output),
    .cycle_clock_oe     (cycle_clock_oe)
  );
  always #2.5 clk = ~clk;
  // each word carries its own address, so a stale fetch shows
  always @(posedge clk) prog_rdata <= 12'hA00 | 12'(prog_addr);
  always @(posedge clk) begin
    cycles++;
    if (cycles > 1000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge clk) master_clear_n <= 1'b0;
    osc_select_bits <= m;
    repeat (5) @(posedge clk);
    #1 check(phase_strobes, 16'h0);
    @(posedge clk) master_clear_n <= 1'b1;
    @(posedge clk) #1 check(phase_strobes, 16'h8);
    check(osc_mode, m);
    check(cycle_clock_oe, m == 2'h3);
    check(cycle_clock_output, m == 2'h3);
  endtask
  task automatic run_cycle(input logic [10:0] a, t, input logic v, br, input logic [11:0] w);
    for (int p = 0; p < 4; p++) begin
      check(phase_strobes, 16'h8 >> p);
      check(exec_ctl, {p == 1 && v, p == 3 && v, v});
      check(decode_word, w);
      check(cycle_clock_output, p < 2);
      if (p == 1) check(prog_addr, a);
      @(posedge clk) exec_branch <= br && p == 2;
      branch_target <= t;
      #1;
    end
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) do_reset(2'(m));
  endtask
  task automatic t_branch();
    run_cycle(11'h0, 11'h0, 1'b0, 1'b0, 12'h0);
    run_cycle(11'h1, 11'h0, 1'b1, 1'b0, 12'hA00);
    run_cycle(11'h2, 11'h155, 1'b1, 1'b1, 12'hA01);
    // a branch asked while the slot is flushed must be ignored
    run_cycle(11'h155, 11'h77, 1'b0, 1'b1, 12'h0);
    run_cycle(11'h156, 11'h0, 1'b1, 1'b0, 12'hB55);
  endtask
  task automatic t_midreset();
    do_reset(2'h3);
    run_cycle(11'h0, 11'h0, 1'b0, 1'b0, 12'h0);
  endtask
  initial begin
    t_modes();
    t_branch();
    t_midreset();
    finish_test();
  end
endmodule // instruction_cycle_sequencer_tb
`default_nettype wire
